// File: common/dsap_defs.vh
// Constants for the serial audio port: register map, fields, formats and timing.
`ifndef DSAP_DEFS_VH
`define DSAP_DEFS_VH

// Register indices on the plain register port.
`define DSAP_REG_MODE 4'h0
`define DSAP_REG_CONFIG 4'h1
`define DSAP_REG_STATUS 4'h2
`define DSAP_REG_ADC_L 4'h3
`define DSAP_REG_ADC_R 4'h4
`define DSAP_REG_RX_L 4'h5
`define DSAP_REG_RX_R 4'h6
`define DSAP_REG_DAC_L 4'h7
`define DSAP_REG_DAC_R 4'h8

// Field positions.
`define DSAP_MCE_BIT 0
`define DSAP_EN_BIT 0
`define DSAP_FMT_LO 1
`define DSAP_FMT_HI 2
`define DSAP_PSEL_BIT 3
`define DSAP_MONO_BIT 4

// Reset values.
`define DSAP_MODE_RST 1'h0
`define DSAP_CONFIG_RST 5'h00

// Frame formats.
`define DSAP_FMT_ENH 2'h0
`define DSAP_FMT_PLAIN 2'h1
`define DSAP_FMT_STOP32 2'h2
`define DSAP_FMT_ECHO 2'h3

// Frame geometry.
`define DSAP_LAST_SLOT 6'h3F
`define DSAP_HALF_SLOT 6'h20
`define DSAP_WORD_SLOTS 6'h10
`define DSAP_STATUS_END 6'h24

// Timing: frame rate, bit clocks per frame, system clock period.
`define DSAP_FRAME_HZ 44100
`define DSAP_SCLK_PER_FRAME 64
`define DSAP_CLK_PERIOD_NS 40
`define DSAP_NS_PER_S 1000000000
`define DSAP_ACC_BITS 24

`endif

// File: design/dsap_bit_clock.v
// Fractional divider that makes the serial bit clock and its edge ticks.
`timescale 1ns/1ps
`include "dsap_defs.vh"

module dsap_bit_clock (
  // Clock, reset and freeze
  input wire clk,
  input wire nrst,
  input wire ce,
  // Control
  input wire run,
  // Bit clock and edge ticks
  output wire sclk,
  output wire riseTick,
  output wire fallTick
);

  // Phase step per system clock for two toggles per bit period.
  localparam [63:0] INC_WIDE = ((64'h2 * `DSAP_SCLK_PER_FRAME * `DSAP_FRAME_HZ
    * `DSAP_CLK_PERIOD_NS) << `DSAP_ACC_BITS) / `DSAP_NS_PER_S;
  localparam [`DSAP_ACC_BITS-1:0] INC = INC_WIDE[`DSAP_ACC_BITS-1:0];

  reg [`DSAP_ACC_BITS-1:0] acc_reg;
  reg bitClk_reg;
  reg rise_reg;
  reg fall_reg;
  wire [`DSAP_ACC_BITS:0] sum = {1'b0, acc_reg} + {1'b0, INC};

  // The edge spacing jitters by one system clock; the average rate is exact
  // to the accumulator resolution, which a 25 MHz clock cannot do by division.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= {`DSAP_ACC_BITS{1'b0}};
      bitClk_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        acc_reg <= {`DSAP_ACC_BITS{1'b0}};
        bitClk_reg <= 1'b0;
        rise_reg <= 1'b0;
        fall_reg <= 1'b0;
      end else begin
        acc_reg <= sum[`DSAP_ACC_BITS-1:0];
        rise_reg <= sum[`DSAP_ACC_BITS] & ~bitClk_reg;
        fall_reg <= sum[`DSAP_ACC_BITS] & bitClk_reg;
        if (sum[`DSAP_ACC_BITS]) begin
          bitClk_reg <= ~bitClk_reg;
        end
      end
    end
  end

  assign sclk = bitClk_reg;
  assign riseTick = rise_reg;
  assign fallTick = fall_reg;

endmodule // dsap_bit_clock

// File: design/dsap_serial_port.v
// Serial audio port: register port, frame engine, pin groups and DAC summing.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "dsap_defs.vh"
// Notes on behaviour
// - Select 0 and enabled: use joystick pins.
// - Select 1 and enabled: use bus pins.
// - Bus pins taken: no host drive on peripherals.
// - Enable changes only while mode change set.
// - Host port stays live, ADC readable.
// - DAC gets serial plus host plus FM.
// - Frames run at fixed 44.1 kHz.
// - All words are 16-bit two's complement.
// - Device drives frame sync and bit clock.
// - Format field picks one of four layouts.
// - Format changes only while mode change set.
// - Mono: zero right out, left to both.
// - Enhanced: 64 clocks, sync pulse precedes frame.
// - Enhanced: four status bits then zeros.
// - Plain: sync high left, low right.
// - 32-clock: clock halts 32 bit periods.
// - Echo: ADC word then DAC word.
// - Echoed DAC words are post-summing values.

module dsap_serial_port (
  // Clock, reset and freeze
  input wire clk,
  input wire nrst,
  input wire ce,
  // Register port
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrStrobe,
  input wire regRdStrobe,
  output wire [15:0] regRdData,
  // Codec sample paths
  input wire [15:0] adcLeft,
  input wire [15:0] adcRight,
  input wire [15:0] hostLeft,
  input wire [15:0] hostRight,
  input wire [15:0] fmLeft,
  input wire [15:0] fmRight,
  output wire [15:0] dacLeft,
  output wire [15:0] dacRight,
  // Host data bus drive on peripheral reads
  input wire periphRead,
  output wire hostDataDriveEn,
  // Joystick B pin group
  output wire joySclkOut,
  output wire joySclkOe,
  output wire joyFsyncOut,
  output wire joyFsyncOe,
  output wire joyDataOut,
  output wire joyDataOe,
  input wire joyDataIn,
  // External bus pins four to one
  output wire xdSclkOut,
  output wire xdSclkOe,
  output wire xdFsyncOut,
  output wire xdFsyncOe,
  output wire xdDataOut,
  output wire xdDataOe,
  input wire xdDataIn
);

  // Control state.
  reg modeChange_reg;
  reg portEnable_reg;
  reg [1:0] format_reg;
  reg pinGroup_reg;
  reg mono_reg;
  reg [15:0] rdData_reg;

  // Frame engine state.
  reg [5:0] slot_reg;
  reg txBit_reg;
  reg [15:0] txAdcL_reg;
  reg [15:0] txAdcR_reg;
  reg [15:0] txDacL_reg;
  reg [15:0] txDacR_reg;
  reg [15:0] rxShL_reg;
  reg [15:0] rxShR_reg;
  reg [15:0] rxL_reg;
  reg [15:0] rxR_reg;
  reg [15:0] dacL_reg;
  reg [15:0] dacR_reg;

  // Input synchronisers and registered pins.
  reg joySync1_reg;
  reg joySync2_reg;
  reg xdSync1_reg;
  reg xdSync2_reg;
  reg pinSclk_reg;
  reg pinFsync_reg;
  reg pinData_reg;

  wire sclk;
  wire riseTick;
  wire fallTick;
  wire [5:0] slotNext = slot_reg + 6'h01;
  wire writeMode = regWrStrobe && (regAddr == `DSAP_REG_MODE);
  wire writeCfg = regWrStrobe && (regAddr == `DSAP_REG_CONFIG);

  dsap_bit_clock dsap_bit_clock_i (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(portEnable_reg),
    .sclk(sclk),
    .riseTick(riseTick),
    .fallTick(fallTick)
  );

  // Control registers.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modeChange_reg <= `DSAP_MODE_RST;
      {mono_reg, pinGroup_reg, format_reg, portEnable_reg} <= `DSAP_CONFIG_RST;
    end else if (ce) begin
      if (writeMode) begin
        modeChange_reg <= regWrData[`DSAP_MCE_BIT];
      end
      if (writeCfg) begin
        pinGroup_reg <= regWrData[`DSAP_PSEL_BIT];
        mono_reg <= regWrData[`DSAP_MONO_BIT];
        if (modeChange_reg) begin
          portEnable_reg <= regWrData[`DSAP_EN_BIT];
        end
        if (modeChange_reg) begin
          format_reg <= regWrData[`DSAP_FMT_HI:`DSAP_FMT_LO];
        end
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_reg <= 16'h0000;
    end else if (ce) begin
      if (regRdStrobe) begin
        case (regAddr)
          `DSAP_REG_MODE: rdData_reg <= {15'h0000, modeChange_reg};
          `DSAP_REG_CONFIG: rdData_reg <= {11'h000, mono_reg, pinGroup_reg,
                                           format_reg, portEnable_reg};
          `DSAP_REG_STATUS: rdData_reg <= {9'h000, slot_reg, sclk};
          `DSAP_REG_ADC_L: rdData_reg <= adcLeft;
          `DSAP_REG_ADC_R: rdData_reg <= adcRight;
          `DSAP_REG_RX_L: rdData_reg <= rxL_reg;
          `DSAP_REG_RX_R: rdData_reg <= rxR_reg;
          `DSAP_REG_DAC_L: rdData_reg <= dacL_reg;
          `DSAP_REG_DAC_R: rdData_reg <= dacR_reg;
          default: rdData_reg <= 16'h0000;
        endcase
      end else begin
        rdData_reg <= 16'h0000;
      end
    end
  end

  // Serial data input of the selected pin group, after two flip-flops.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      joySync1_reg <= 1'b0;
      joySync2_reg <= 1'b0;
      xdSync1_reg <= 1'b0;
      xdSync2_reg <= 1'b0;
    end else if (ce) begin
      joySync1_reg <= joyDataIn;
      joySync2_reg <= joySync1_reg;
      xdSync1_reg <= xdDataIn;
      xdSync2_reg <= xdSync1_reg;
    end
  end

  wire rxBit = pinGroup_reg ? xdSync2_reg : joySync2_reg;

  // Words of the frame being sent, with mono zeroing the right slot.
  // zero right in mono
  wire [15:0] adcRTx = mono_reg ? 16'h0000 : txAdcR_reg;
  wire [3:0] bitIdx = 4'hF - slotNext[3:0];
  wire [5:0] statusOff = slotNext - `DSAP_HALF_SLOT;
  wire [3:0] statusWord = {mono_reg, pinGroup_reg, format_reg};

  // Bit to put on the line in the slot that the next falling edge opens.
  // format select
  reg txBitNext;
  always @* begin
    txBitNext = 1'b0;
    case (format_reg)
      `DSAP_FMT_ENH: begin
        if (slotNext < `DSAP_WORD_SLOTS) begin
          txBitNext = txAdcL_reg[bitIdx];
        end else if (slotNext < `DSAP_HALF_SLOT) begin
          txBitNext = adcRTx[bitIdx];
        end else if (slotNext < `DSAP_STATUS_END) begin
          txBitNext = statusWord[2'h3 - statusOff[1:0]];
        end
      end
      `DSAP_FMT_PLAIN: begin
        case (slotNext[5:4])
          2'h0: txBitNext = txAdcL_reg[bitIdx];
          2'h2: txBitNext = adcRTx[bitIdx];
          default: txBitNext = 1'b0;
        endcase
      end
      `DSAP_FMT_STOP32: begin
        if (slotNext < `DSAP_WORD_SLOTS) begin
          txBitNext = txAdcL_reg[bitIdx];
        end else if (slotNext < `DSAP_HALF_SLOT) begin
          txBitNext = adcRTx[bitIdx];
        end
      end
      `DSAP_FMT_ECHO: begin
        case (slotNext[5:4])
          2'h0: txBitNext = txAdcL_reg[bitIdx];
          2'h1: txBitNext = txDacL_reg[bitIdx];
          2'h2: txBitNext = adcRTx[bitIdx];
          default: txBitNext = txDacR_reg[bitIdx];
        endcase
      end
      default: txBitNext = 1'b0;
    endcase
  end

  // Formats 00 and 10 pack the right word straight after the left.
  wire rightAt16 = (format_reg == `DSAP_FMT_ENH) || (format_reg == `DSAP_FMT_STOP32);
  wire inLeft = slot_reg < `DSAP_WORD_SLOTS;
  wire inRight = rightAt16 ?
    ((slot_reg >= `DSAP_WORD_SLOTS) && (slot_reg < `DSAP_HALF_SLOT)) :
    (slot_reg[5:4] == 2'h2);
  wire [3:0] rxIdx = 4'hF - slot_reg[3:0];
  wire frameEnd = riseTick && (slot_reg == `DSAP_LAST_SLOT);

  // Frame engine: slot count, transmit bit, receive shift, word capture.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot_reg <= `DSAP_LAST_SLOT;
      txBit_reg <= 1'b0;
      txAdcL_reg <= 16'h0000;
      txAdcR_reg <= 16'h0000;
      txDacL_reg <= 16'h0000;
      txDacR_reg <= 16'h0000;
      rxShL_reg <= 16'h0000;
      rxShR_reg <= 16'h0000;
      rxL_reg <= 16'h0000;
      rxR_reg <= 16'h0000;
    end else if (ce) begin
      if (!portEnable_reg) begin
        // Parking on the last slot makes the first falling edge open slot 0.
        slot_reg <= `DSAP_LAST_SLOT;
        txBit_reg <= 1'b0;
      end else begin
        if (fallTick) begin
          slot_reg <= slotNext;
          txBit_reg <= txBitNext;
        end
        if (riseTick && inLeft) begin
          rxShL_reg[rxIdx] <= rxBit;
        end
        if (riseTick && inRight) begin
          rxShR_reg[rxIdx] <= rxBit;
        end
        if (frameEnd) begin
          rxL_reg <= rxShL_reg;
          rxR_reg <= rxShR_reg;
          txAdcL_reg <= adcLeft;
          txAdcR_reg <= adcRight;
          txDacL_reg <= dacL_reg;
          txDacR_reg <= dacR_reg;
        end
      end
    end
  end

  // Three-way sum with saturation to the 16-bit signed range.
  function [15:0] dsapSat3;
    input [15:0] a;
    input [15:0] b;
    input [15:0] c;
    reg [17:0] s;
    begin
      s = {{2{a[15]}}, a} + {{2{b[15]}}, b} + {{2{c[15]}}, c};
      if (!s[17] && (s[16:15] != 2'h0)) begin
        dsapSat3 = 16'h7FFF;
      end else if (s[17] && (s[16:15] != 2'h3)) begin
        dsapSat3 = 16'h8000;
      end else begin
        dsapSat3 = s[15:0];
      end
    end
  endfunction

  wire [15:0] serL = portEnable_reg ? rxL_reg : 16'h0000;
  wire [15:0] serR = portEnable_reg ? (mono_reg ? rxL_reg : rxR_reg) : 16'h0000;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dacL_reg <= 16'h0000;
      dacR_reg <= 16'h0000;
    end else if (ce) begin
      dacL_reg <= dsapSat3(serL, hostLeft, fmLeft);
      dacR_reg <= dsapSat3(serR, hostRight, fmRight);
    end
  end

  // Line levels, registered together so clock, sync and data stay aligned.
  reg fsyncNow;
  always @* begin
    fsyncNow = 1'b0;
    case (format_reg)
      `DSAP_FMT_ENH: fsyncNow = (slot_reg == `DSAP_LAST_SLOT);
      `DSAP_FMT_STOP32: fsyncNow = (slot_reg < `DSAP_WORD_SLOTS);
      default: fsyncNow = (slot_reg < `DSAP_HALF_SLOT);
    endcase
  end

  wire sclkHalt = (format_reg == `DSAP_FMT_STOP32) && (slot_reg >= `DSAP_HALF_SLOT);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinSclk_reg <= 1'b0;
      pinFsync_reg <= 1'b0;
      pinData_reg <= 1'b0;
    end else if (ce) begin
      pinSclk_reg <= portEnable_reg & sclk & ~sclkHalt;
      pinFsync_reg <= portEnable_reg & fsyncNow;
      pinData_reg <= txBit_reg;
    end
  end

  wire joyOn = portEnable_reg && !pinGroup_reg;
  wire xdOn = portEnable_reg && pinGroup_reg;

  assign joySclkOut = pinSclk_reg & joyOn;
  assign joySclkOe = joyOn;
  assign joyFsyncOut = pinFsync_reg & joyOn;
  assign joyFsyncOe = joyOn;
  assign joyDataOut = pinData_reg & joyOn;
  assign joyDataOe = joyOn;
  assign xdSclkOut = pinSclk_reg & xdOn;
  assign xdSclkOe = xdOn;
  assign xdFsyncOut = pinFsync_reg & xdOn;
  assign xdFsyncOe = xdOn;
  assign xdDataOut = pinData_reg & xdOn;
  assign xdDataOe = xdOn;

  assign hostDataDriveEn = periphRead & ~xdOn;

  assign regRdData = rdData_reg;
  assign dacLeft = dacL_reg;
  assign dacRight = dacR_reg;

endmodule // dsap_serial_port

// File: verif/dsap_serial_port_sva.sv
// Checker on the serial audio port's top-level ports.
`timescale 1ns/1ps
`include "dsap_defs.vh"
module dsap_serial_port_sva (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port and sample paths
  input wire [3:0] regAddr,
  input wire regRdStrobe,
  input wire [15:0] regRdData,
  input wire [15:0] adcRight,
  input wire [15:0] hostLeft,
  input wire [15:0] fmLeft,
  input wire [15:0] dacLeft,
  // Pins
  input wire periphRead,
  input wire hostDataDriveEn,
  input wire joySclkOut,
  input wire joySclkOe,
  input wire joyFsyncOut,
  input wire joyFsyncOe,
  input wire joyDataOut,
  input wire joyDataOe,
  input wire xdSclkOe,
  input wire xdFsyncOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles between sync rises; the first rise after enable only arms the check.
  reg [9:0] gap_reg;
  reg seen_reg;
  reg fsPrev_reg;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= 10'h000;
      seen_reg <= 1'b0;
      fsPrev_reg <= 1'b0;
    end else if (!joyFsyncOe) begin
      // A released group restarts the count, so a new enable only arms the check.
      gap_reg <= 10'h000;
      seen_reg <= 1'b0;
      fsPrev_reg <= 1'b0;
    end else begin
      fsPrev_reg <= joyFsyncOut;
      seen_reg <= seen_reg | (joyFsyncOut & ~fsPrev_reg);
      gap_reg <= (joyFsyncOut && !fsPrev_reg) ? 10'h001 : gap_reg + 10'h001;
    end
  end
  group_excl_a: assert property (!(joySclkOe && xdSclkOe))
    else $error("Both pin groups driven.");
  host_drive_a: assert property (hostDataDriveEn == (periphRead && !xdSclkOe))
    else $error("Host bus drive wrong.");
  oe_together_a: assert property (joySclkOe == joyFsyncOe && joySclkOe == joyDataOe
    && xdSclkOe == xdFsyncOe) else $error("Pin enables disagree.");
  gated_pins_a: assert property (!joySclkOe |-> !(joySclkOut || joyFsyncOut || joyDataOut))
    else $error("Undriven pin shows a level.");
  read_stands_a: assert property (!$past(regRdStrobe) |-> regRdData == 16'h0000)
    else $error("Read data outside its cycle.");
  adc_read_a: assert property (regRdStrobe && regAddr == `DSAP_REG_ADC_R
    |=> regRdData == $past(adcRight)) else $error("ADC read wrong.");
  unmapped_read_a: assert property (regRdStrobe && regAddr > 4'h8 |=> regRdData == 16'h0000)
    else $error("Unmapped read not zero.");
  dac_sum_a: assert property ($past(nrst) && !$past(joySclkOe) && !$past(xdSclkOe)
    |-> dacLeft == $past(hostLeft) + $past(fmLeft)) else $error("DAC sum wrong.");
  frame_rate_a: assert property (joyFsyncOut && !fsPrev_reg && seen_reg
    |-> gap_reg >= 10'h235 && gap_reg <= 10'h238) else $error("Frame period wrong.");
  sclk_high_a: assert property (disable iff (!nrst || !joySclkOe) $rose(joySclkOut)
    |-> joySclkOut[*4] ##[1:2] !joySclkOut) else $error("Bit clock high phase wrong.");
  cover property ($rose(joySclkOe));
  cover property (xdSclkOe && periphRead);
  cover property (regRdStrobe && regAddr == 4'hF);
endmodule // dsap_serial_port_sva
bind dsap_serial_port dsap_serial_port_sva dsap_serial_port_sva_i (.clk, .nrst, .regAddr,
  .regRdStrobe, .regRdData, .adcRight, .hostLeft, .fmLeft, .dacLeft, .periphRead,
  .hostDataDriveEn, .joySclkOut, .joySclkOe, .joyFsyncOut, .joyFsyncOe, .joyDataOut,
  .joyDataOe, .xdSclkOe, .xdFsyncOe);

// File: verif/dsap_dsp_model.sv
// Far-end serial device: follows the port's bit clock and frame sync.
`timescale 1ns/1ps
module dsap_dsp_model (
  // Link wires
  input wire sclk,
  input wire frame_sync,
  input wire sdo,
  output reg sdi,
  // Control and captured frame
  input wire enhanced,
  input wire [63:0] txFrame,
  output reg [63:0] lastFrame
);
  reg [63:0] rxFrame_reg;
  reg [5:0] slot_reg;
  reg fsPrev_reg;
  initial {sdi, lastFrame, rxFrame_reg, slot_reg, fsPrev_reg} = '0;
  always @(posedge sclk) begin
    fsPrev_reg <= frame_sync;
    if (enhanced ? fsPrev_reg : (frame_sync && !fsPrev_reg)) begin
      lastFrame <= rxFrame_reg;
      slot_reg <= 6'h00;
      rxFrame_reg[63] <= sdo;
    end else begin
      slot_reg <= slot_reg + 6'h01;
      rxFrame_reg[6'h3E - slot_reg] <= sdo;
    end
  end
  always @(negedge sclk) begin
    sdi <= txFrame[6'h3E - slot_reg];
  end
endmodule // dsap_dsp_model

// File: verif/tb_dsap_serial_port.sv
// Self-checking bench for the serial audio port against a far-end model.
`timescale 1ns/1ps
`include "dsap_defs.vh"
module tb_dsap_serial_port;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, regWrStrobe = 1'b0, regRdStrobe = 1'b0;
  logic periphRead = 1'b0, enh = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, adcLeft = 16'h0000, adcRight = 16'h0000;
  logic [15:0] hostLeft = 16'h0000, hostRight = 16'h0000, fmLeft = 16'h0000, fmRight = 16'h0000;
  logic [63:0] txFrame = 64'h0;
  wire [15:0] regRdData, dacLeft, dacRight;
  wire hostDataDriveEn, joySclkOut, joySclkOe, joyFsyncOut, joyFsyncOe, joyDataOut, joyDataOe;
  wire xdSclkOut, xdSclkOe, xdFsyncOut, xdFsyncOe, xdDataOut, xdDataOe, sdi;
  wire [63:0] heard;
  int n_mismatch = 0, checks_done = 0;
  // Outputs are gated to 0 when undriven, so OR-ing gives the selected group.
  wire sclkW = joySclkOut | xdSclkOut;
  wire fsW = joyFsyncOut | xdFsyncOut;
  // An unselected input sees the inverse, never a stale copy of the data.
  wire joyDataIn = joyDataOe ? sdi : !sdi;
  wire xdDataIn = xdDataOe ? sdi : !sdi;
  always #20 clk = ~clk;
  dsap_serial_port dsap_serial_port_i (.clk, .nrst, .ce, .regAddr, .regWrData, .regWrStrobe,
    .regRdStrobe, .regRdData, .adcLeft, .adcRight, .hostLeft, .hostRight, .fmLeft, .fmRight,
    .dacLeft, .dacRight, .periphRead, .hostDataDriveEn, .joySclkOut, .joySclkOe, .joyFsyncOut,
    .joyFsyncOe, .joyDataOut, .joyDataOe, .joyDataIn, .xdSclkOut, .xdSclkOe, .xdFsyncOut,
    .xdFsyncOe, .xdDataOut, .xdDataOe, .xdDataIn);
  dsap_dsp_model dsap_dsp_model_i (.sclk(sclkW), .frame_sync(fsW), .sdo(joyDataOut | xdDataOut),
    .sdi, .enhanced(enh), .txFrame, .lastFrame(heard));
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1 v = regRdData;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task t_gate;
    logic [15:0] d;
    rd(4'hF, d);
    chk({d, joySclkOe, xdSclkOe}, 18'h0);
    wr(`DSAP_REG_CONFIG, 16'h0013);
    rd(`DSAP_REG_CONFIG, d);
    chk({d, joySclkOe}, 17'h00020);
    wr(`DSAP_REG_MODE, 16'h0001);
    wr(`DSAP_REG_CONFIG, 16'h0003);
    periphRead <= 1'b1;
    @(posedge clk);
    #1 chk({joySclkOe, xdSclkOe, hostDataDriveEn}, 3'b101);
    $display("gate test done");
  endtask
  task t_frame(input logic [1:0] f, input logic g, input logic m);
    logic [15:0] d, aL, aR, dL, dR, eR;
    logic [63:0] e;
    logic pS, pF;
    int n;
    aL = 16'h5A50 + f;
    aR = 16'hC3C0 + f;
    dL = 16'h1344 + f + g;
    dR = (m ? 16'h1234 : 16'h0ABC) + 16'h0220 + m + g;
    eR = m ? 16'h0000 : aR;
    wr(`DSAP_REG_CONFIG, 16'h0000);
    adcLeft <= aL;
    adcRight <= aR;
    hostLeft <= 16'h0100 + f;
    hostRight <= 16'h0200 + m;
    fmLeft <= 16'h0010 + g;
    fmRight <= 16'h0020 + g;
    enh <= (f == `DSAP_FMT_ENH);
    txFrame <= f[0] ? {16'h1234, 16'h0, 16'h0ABC, 16'h0} : {2{16'h1234, 16'h0ABC}};
    wr(`DSAP_REG_CONFIG, {11'h0, m, g, f, 1'b1});
    repeat (1800) @(posedge clk);
    @(posedge fsW);
    @(posedge clk);
    #1;
    n = 0;
    pS = sclkW;
    pF = fsW;
    for (int i = 0; i < 700; i++) begin
      @(posedge clk);
      // Look after the edge, once the registered pins have settled.
      #1;
      if (sclkW && !pS) n++;
      if (fsW && !pF) break;
      pS = sclkW;
      pF = fsW;
    end
    chk(n, f == `DSAP_FMT_STOP32 ? 32 : 64);
    case (f)
      2'h0: e = {aL, eR, m, g, f, 28'h0};
      2'h1: e = {aL, 16'h0, eR, 16'h0};
      2'h2: e = {aL, eR, 32'h0};
      default: e = {aL, dL, eR, dR};
    endcase
    chk(f == 2'h2 ? {heard[63:32], 32'h0} : heard, e);
    chk({dacLeft, dacRight}, {dL, dR});
    chk({joySclkOe, xdSclkOe, hostDataDriveEn}, {!g, g, !g});
    rd(`DSAP_REG_RX_L, d);
    chk(d, 16'h1234);
    rd(`DSAP_REG_ADC_R, d);
    chk(d, aR);
    $display("frame test %0d done", f);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_gate;
    t_frame(2'h0, 1'b1, 1'b1);
    t_frame(2'h1, 1'b0, 1'b0);
    t_frame(2'h2, 1'b0, 1'b0);
    t_frame(2'h3, 1'b1, 1'b0);
    wr(`DSAP_REG_CONFIG, 16'h0000);
    tally_and_finish;
  end
  initial begin
    #(40 * 20000);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // tb_dsap_serial_port
